// ### tb/isah_assertions.sv
// concurrent checks on the bus between the host end and the device end
`timescale 1ns/1ps
module isah_assertions (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       sclk,
  input wire logic       system_reset_in,
  input wire logic       io_write_strobe_n,
  input wire logic       io_read_strobe_n,
  input wire logic       memr_n,
  input wire logic       hd_oe,
  input wire logic [1:0] dd_oe,
  input wire logic       rdy_out,
  input wire logic       rdy_oe,
  input wire logic       io16_oe,
  input wire logic       nws_oe,
  input wire logic       chk_n,
  input wire logic [9:0] irq,
  input wire logic       spk_dev_oe
);
  logic       sclk_q;
  logic [2:0] chk_cnt_q;
  // ----------------
  // helper logic
  // ----------------
  always_ff @(posedge CLK_I) begin
    sclk_q <= sclk;
  end
  // raw bus clock rises counted while the check line is low
  always_ff @(posedge CLK_I) begin
    if (RST_I || chk_n) begin
      chk_cnt_q <= 3'h0;
    end else if (sclk && !sclk_q && chk_cnt_q != 3'h7) begin
      chk_cnt_q <= chk_cnt_q + 3'h1;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ----------------
  // properties
  // ----------------
  AST_CHK_WIDTH: assert property ($rose(chk_n) |-> chk_cnt_q == 3'h3)
    else $error("check pulse length wrong");
  AST_RDY_ONE_WAIT: assert property ($rose(rdy_oe) |-> ##[1:12] !rdy_oe)
    else $error("ready held low too long");
  AST_RDY_OPEN_DRAIN: assert property (rdy_oe |-> !rdy_out)
    else $error("ready driven high");
  AST_IO16_NO_ZWS: assert property (io16_oe && !(io_read_strobe_n && io_write_strobe_n) |-> !nws_oe)
    else $error("zero wait in 16-bit io cycle");
  AST_SYSTEM_RESET_IN_QUIET: assert property (system_reset_in [*5] |-> !rdy_oe && !nws_oe && !io16_oe && dd_oe == 2'h0 && chk_n)
    else $error("outputs active during system reset");
  AST_SPK_DRIVEN: assert property (!system_reset_in [*6] |-> spk_dev_oe)
    else $error("speaker pin not driven");
  AST_DATA_RELEASED: assert property ((io_read_strobe_n && memr_n) [*5] |-> dd_oe == 2'h0)
    else $error("data driven outside a read");
  AST_NO_FIGHT: assert property (!(hd_oe && dd_oe != 2'h0))
    else $error("both ends drive data");
  AST_IRQ_PER_SOCKET: assert property ($countones(irq) <= 2)
    else $error("more interrupt lines than sockets");
endmodule

// ### tb/isah_host_side_interface_tb.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
module isah_host_side_interface_tb;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, sys_rst = 1'b1, strap = 1'b0, vld = 1'b0;
  logic        io = 1'b0, wr = 1'b0, word = 1'b0, wait_en = 1'b0, zws_en = 1'b0, nmi = 1'b0, spk = 1'b0;
  logic        io16 = 1'b1;
  logic [1:0]  sock = 2'h0, seen16;
  logic [7:0]  irq_sel = 8'hFF, reg_rd = 8'h00, reg_wd;
  logic [15:0] wdata = 16'h0000, card_rd = 16'h0000, io_lo = 16'h0300, io_hi = 16'h030F, rdata, c_wd;
  logic [11:0] m_lo = 12'hA40, m_hi = 12'hA4F;
  logic [23:0] addr = 24'h000000, c_addr;
  logic        ready, rsp, zws, nmi_n, spk_o, base_sel, reg_wr, reg_a, c_io, c_wr, c_word;
  logic [9:0]  irq_o;
  logic [8:0]  exp_q[$], got_q[$];
  int          bad_count = 0, checked = 0;
  isah_if bus ();
  isah_device u_isah_device (.CLK_I(clk), .RST_I(rst), .CE_I(en), .BUS(bus), .WAIT_EN_I(wait_en),
    .ZERO_WAIT_EN_I(zws_en), .IO_WIN_EN_I(en), .IO_WIN_LO_I(io_lo), .IO_WIN_HI_I(io_hi), .IO16_MODE_I(io16),
    .MEM_WIN_EN_I(en), .MEM_WIN_LO_I(m_lo), .MEM_WIN_HI_I(m_hi), .MEM16_MODE_I(en), .SOCK_IRQ_I(sock),
    .IRQ_SEL_I(irq_sel), .NMI_REQ_I(nmi), .SPKR_AUDIO_I(spk), .REG_RDATA_I(reg_rd), .CARD_RDATA_I(card_rd),
    .BASE_SEL_O(base_sel), .REG_WR_O(reg_wr), .REG_ADDR_O(reg_a), .REG_WDATA_O(reg_wd), .CARD_STB_O(),
    .CARD_IO_O(c_io), .CARD_WR_O(c_wr), .CARD_WORD_O(c_word), .CARD_ADDR_O(c_addr), .CARD_WDATA_O(c_wd));
  isah_host u_isah_host (.CLK_I(clk), .RST_I(rst), .CE_I(en), .BUS(bus), .SYS_RESET_I(sys_rst),
    .STRAP_SEL_I(strap), .CMD_VALID_I(vld), .CMD_IO_I(io), .CMD_WR_I(wr), .CMD_WORD_I(word),
    .CMD_ADDR_I(addr), .CMD_WDATA_I(wdata), .CMD_READY_O(ready), .RSP_VALID_O(rsp), .RSP_RDATA_O(rdata),
    .RSP_ZWS_O(zws), .IRQ_O(irq_o), .NMI_N_O(nmi_n), .SPKR_O(spk_o));
  isah_assertions u_chk (.CLK_I(clk), .RST_I(rst), .sclk(bus.sclk), .system_reset_in(bus.system_reset_in), .io_write_strobe_n(bus.io_write_strobe_n),
    .io_read_strobe_n(bus.io_read_strobe_n), .memr_n(bus.memr_n), .hd_oe(bus.hd_oe), .dd_oe(bus.dd_oe), .rdy_out(bus.rdy_out),
    .rdy_oe(bus.rdy_oe), .io16_oe(bus.io16_oe), .nws_oe(bus.nws_oe), .chk_n(bus.chk_n), .irq(bus.irq),
    .spk_dev_oe(bus.spk_dev_oe));
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (reg_wr === 1'b1) got_q.push_back({reg_a, reg_wd});
  end
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(negedge clk);
    n++;
    if (n > 3000) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // one host cycle; records which width select the host saw while its strobe was low
  task automatic cmd(input logic i, w, wd, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    seen16 = 2'h0;
    tick(n);
    while (ready !== 1'b1) tick(n);
    {io, wr, word, addr, wdata, vld} = {i, w, wd, a, d, 1'b1};
    tick(n);
    vld = 1'b0;
    while (rsp !== 1'b1) begin
      tick(n);
      // selects follow the address alone, so a stale address before the strobe must not count
      if ((bus.io_read_strobe_n & bus.io_write_strobe_n & bus.memr_n & bus.memw_n) !== 1'b1)
        seen16 |= {bus.io16_n_lvl === 1'b0, bus.mem16_lvl === 1'b1};
    end
  endtask
  task automatic sys_reset(input logic s);
    int n;
    n = 0;
    strap = s;
    sys_rst = 1'b1;
    repeat (6) tick(n);
    sys_rst = 1'b0;
    repeat (8) tick(n);
  endtask
  // ----------------
  // scenarios
  // ----------------
  initial begin
    logic [15:0] d;
    logic [23:0] a;
    int n;
    void'($urandom(89168));
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int s = 0; s < 2; s++) begin
      sys_reset(s[0]);
      chk("base_sel", s, base_sel);
      d = 16'($urandom);
      cmd(1, 1, 0, 24'h0003E0 + 24'(2 * s), d);
      exp_q.push_back({1'b0, d[7:0]});
      cmd(1, 1, 0, 24'h0003E2 - 24'(2 * s), ~d);
      reg_rd = 8'($urandom);
      cmd(1, 0, 0, 24'h0003E0 + 24'(2 * s), 16'h0000);
      chk("reg_read", {8'hFF, reg_rd}, rdata);
    end
    for (int i = 0; i < 8; i++) begin
      {io16, zws_en, wait_en} = 3'(i);
      a = 24'hA48000 | (24'($urandom) & 24'h007FFE);
      card_rd = 16'($urandom);
      d = 16'($urandom);
      cmd(0, 0, 1, a, 16'h0000);
      chk("mem_rdata", card_rd, rdata);
      chk("mem_zws", i % 4 == 2, zws);
      chk("mem16_seen", 2'h1, seen16);
      cmd(0, 1, 1, a | 24'h000001, d);
      chk("card_addr", {2'h3, a[23:1], 1'b0}, {c_wr, c_word, c_addr});
      chk("card_wdata", d, c_wd);
      cmd(1, 0, 1, 24'h000304, 16'h0000);
      chk("io_zws", i == 2, zws);
      chk("io16_seen", io16 ? {2'h2, card_rd} : {10'h0FF, card_rd[7:0]}, {seen16, rdata});
      cmd(1, 1, 1, 24'h000306, d);
      chk("io_wdata", {1'b1, d}, {c_io, c_wd});
    end
    for (int k = 0; k < 20; k++) begin
      irq_sel = (k < 10) ? {4'hF, 4'(k)} : {4'(k - 10), 4'hF};
      sock = (k < 10) ? 2'h1 : 2'h2;
      repeat (8) @(negedge clk);
      chk("irq", 32'h1 << (k % 10), irq_o);
      sock = 2'h0;
      repeat (8) @(negedge clk);
      chk("irq_clear", 0, irq_o);
    end
    // second pass raises the check from a socket routed to the check code
    for (int j = 0; j < 2; j++) begin
      n = 0;
      if (j == 0) nmi = 1'b1;
      else {irq_sel, sock} = {8'hFA, 2'h1};
      while (nmi_n !== 1'b0) tick(n);
      n = 0;
      while (nmi_n === 1'b0) tick(n);
      chk("nmi_width", 32'(isah_pkg::CHK_SCLKS) * 2 * isah_pkg::SCLK_HALF, n);
      {nmi, sock} = 3'h0;
      repeat (40) @(negedge clk);
    end
    for (int j = 0; j < 4; j++) begin
      spk = 1'($urandom);
      repeat (8) @(negedge clk);
      chk("spkr", spk, spk_o);
    end
    chk("reg_writes", exp_q.size(), got_q.size());
    foreach (exp_q[q]) if (q < got_q.size()) chk("reg_write", exp_q[q], got_q[q]);
    print_verdict();
  end
endmodule

// ### verilog/isah_device.sv
// device end: decodes host cycles, drives width, ready, wait, interrupt and speaker pins
`timescale 1ns/1ps
module isah_device #(
  parameter int IRQ_N = isah_pkg::IRQ_LINES
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  isah_if.dev              BUS,
  input  wire logic        WAIT_EN_I,
  input  wire logic        ZERO_WAIT_EN_I,
  input  wire logic        IO_WIN_EN_I,
  input  wire logic [15:0] IO_WIN_LO_I,
  input  wire logic [15:0] IO_WIN_HI_I,
  input  wire logic        IO16_MODE_I,
  input  wire logic        MEM_WIN_EN_I,
  input  wire logic [11:0] MEM_WIN_LO_I,
  input  wire logic [11:0] MEM_WIN_HI_I,
  input  wire logic        MEM16_MODE_I,
  input  wire logic [1:0]  SOCK_IRQ_I,
  input  wire logic [7:0]  IRQ_SEL_I,
  input  wire logic        NMI_REQ_I,
  input  wire logic        SPKR_AUDIO_I,
  input  wire logic [7:0]  REG_RDATA_I,
  input  wire logic [15:0] CARD_RDATA_I,
  output logic             BASE_SEL_O,
  output logic             REG_WR_O,
  output logic             REG_ADDR_O,
  output logic [7:0]       REG_WDATA_O,
  output logic             CARD_STB_O,
  output logic             CARD_IO_O,
  output logic             CARD_WR_O,
  output logic             CARD_WORD_O,
  output logic [23:0]      CARD_ADDR_O,
  output logic [15:0]      CARD_WDATA_O
);
  localparam int SW = 50;

  logic [SW-1:0]         raw;
  logic [SW-1:0]         syn;
  logic [6:0]            la_s;
  logic [16:0]           sa_s;
  logic                  bale_s;
  logic                  sclk_s;
  logic                  io_write_strobe_n_s;
  logic                  io_read_strobe_n_s;
  logic                  memw_n_s;
  logic                  memr_n_s;
  logic                  sbhe_n_s;
  logic                  aen_s;
  logic                  system_reset_in_s;
  logic                  spk_s;
  logic [15:0]           d_s;
  logic                  rst;
  logic                  sclk_q;
  logic                  sclk_rise;
  logic                  sel_q;
  logic [6:0]            la_q;
  logic [23:0]           addr;
  logic [23:0]           eff;
  logic [15:0]           reg_base;
  logic                  io_act;
  logic                  mem_act;
  logic                  reg_hit;
  logic                  io_sel;
  logic                  mem_sel;
  logic                  io_hit;
  logic                  mem_hit;
  logic                  card_hit;
  logic                  word;
  logic                  wr;
  logic                  act;
  logic                  act_q;
  logic                  start;
  logic                  reg_wr_q;
  logic [isah_pkg::CNT_W-1:0] wait_q;
  logic [isah_pkg::CNT_W-1:0] wait_d;
  logic [isah_pkg::CNT_W-1:0] dly_q;
  logic [isah_pkg::CNT_W-1:0] dly_d;
  logic [isah_pkg::CNT_W-1:0] chk_q;
  logic [isah_pkg::CNT_W-1:0] chk_d;
  logic                  chk_req;
  logic                  chk_req_q;
  logic                  chk_pend_q;
  logic [IRQ_N-1:0]      irq_d;

  assign raw = {BUS.la, BUS.sa, BUS.bale, BUS.sclk, BUS.io_write_strobe_n, BUS.io_read_strobe_n, BUS.memw_n, BUS.memr_n,
                BUS.sbhe_n, BUS.aen, BUS.system_reset_in, BUS.spk_lvl, BUS.d_lvl};

  isah_sync #(.W(SW)) u_sync (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .CE_I  (CE_I),
    .D_I   (raw),
    .Q_O   (syn)
  );

  assign {la_s, sa_s, bale_s, sclk_s, io_write_strobe_n_s, io_read_strobe_n_s, memw_n_s, memr_n_s, sbhe_n_s, aen_s, system_reset_in_s,
          spk_s, d_s} = syn;

  //----------------------------------------------------------------------------
  // reset, bus clock edges, base select
  //----------------------------------------------------------------------------
  assign rst       = RST_I | system_reset_in_s;
  assign sclk_rise = sclk_s & ~sclk_q;

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      sclk_q <= 1'b1;
    end else if (CE_I) begin
      sclk_q <= sclk_s;
    end
  end

  // strap sampled during system reset; only a bench reset clears it
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      sel_q <= isah_pkg::SEL_RST;
    end else if (CE_I && system_reset_in_s) begin
      sel_q <= spk_s;
    end
  end

  //----------------------------------------------------------------------------
  // address latch and decode
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      la_q <= 7'h00;
    end else if (CE_I && bale_s) begin
      la_q <= la_s;
    end
  end

  assign addr     = {la_q, sa_s};
  assign reg_base = sel_q ? isah_pkg::REG_BASE1 : isah_pkg::REG_BASE0;
  assign io_act   = ~aen_s & (~io_read_strobe_n_s | ~io_write_strobe_n_s);
  assign mem_act  = ~memr_n_s | ~memw_n_s;
  assign reg_hit  = io_act & (sa_s[15:1] == reg_base[15:1]);
  assign io_sel   = ~aen_s & IO_WIN_EN_I & (sa_s[15:0] >= IO_WIN_LO_I) & (sa_s[15:0] <= IO_WIN_HI_I)
                    & (sa_s[15:1] != reg_base[15:1]);
  assign mem_sel  = MEM_WIN_EN_I & (addr[23:12] >= MEM_WIN_LO_I) & (addr[23:12] <= MEM_WIN_HI_I);
  assign io_hit   = io_act & io_sel;
  assign mem_hit  = mem_act & mem_sel;
  assign card_hit = io_hit | mem_hit;
  assign word     = ~sbhe_n_s & (io_hit ? IO16_MODE_I : MEM16_MODE_I);
  assign eff      = word ? {addr[23:1], 1'b0} : addr;
  assign wr       = ~io_write_strobe_n_s | ~memw_n_s;
  assign act      = reg_hit | card_hit;
  assign start    = act & ~act_q;

  //----------------------------------------------------------------------------
  // wait, strobe delay and check pulse counters, all in bus clock periods
  //----------------------------------------------------------------------------
  always_comb begin
    wait_d = wait_q;
    dly_d  = dly_q;
    chk_d  = chk_q;
    if (start && card_hit) begin
      wait_d = WAIT_EN_I ? isah_pkg::WAIT_SCLKS : '0;
      dly_d  = (mem_hit && MEM16_MODE_I) ? isah_pkg::MEM16_DLY_SCLKS : '0;
    end else if (!act) begin
      wait_d = '0;
      dly_d  = '0;
    end else if (sclk_rise) begin
      if (wait_q != '0) begin
        wait_d = wait_q - 1'b1;
      end
      if (dly_q != '0) begin
        dly_d = dly_q - 1'b1;
      end
    end
    if (sclk_rise) begin
      if (chk_q != '0) begin
        chk_d = chk_q - 1'b1;
      end else if (chk_pend_q) begin
        chk_d = isah_pkg::CHK_SCLKS;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      act_q  <= 1'b0;
      wait_q <= '0;
      dly_q  <= '0;
      chk_q  <= '0;
    end else if (CE_I) begin
      act_q  <= act;
      wait_q <= wait_d;
      dly_q  <= dly_d;
      chk_q  <= chk_d;
    end
  end

  //----------------------------------------------------------------------------
  // channel check request: a new request while a pulse runs waits for the next one
  //----------------------------------------------------------------------------
  always_comb begin
    chk_req = NMI_REQ_I;
    for (int s = 0; s < isah_pkg::SOCKETS; s++) begin
      chk_req = chk_req | (SOCK_IRQ_I[s] & (IRQ_SEL_I[s*4 +: 4] == isah_pkg::IRQ_CODE_CHK));
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst) begin
      chk_req_q  <= 1'b0;
      chk_pend_q <= 1'b0;
    end else if (CE_I) begin
      chk_req_q <= chk_req;
      if (chk_req && !chk_req_q) begin
        chk_pend_q <= 1'b1;
      end else if (sclk_rise && chk_q == '0) begin
        chk_pend_q <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------------------
  // interrupt routing
  //----------------------------------------------------------------------------
  for (genvar k = 0; k < IRQ_N; k++) begin : g_irq
    assign irq_d[k] = (SOCK_IRQ_I[0] & (IRQ_SEL_I[3:0] == 4'(k))) |
                      (SOCK_IRQ_I[1] & (IRQ_SEL_I[7:4] == 4'(k)));
  end

  //----------------------------------------------------------------------------
  // pin drivers, all registered
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      BUS.dd_out      <= 16'hFFFF;
      BUS.dd_oe       <= 2'h0;
      BUS.rdy_out     <= 1'b0;
      BUS.rdy_oe      <= 1'b0;
      BUS.io16_oe     <= 1'b0;
      BUS.mem16_out   <= 1'b1;
      BUS.mem16_oe    <= 1'b0;
      BUS.nws_oe      <= 1'b0;
      BUS.chk_n       <= 1'b1;
      BUS.irq         <= '0;
      BUS.spk_dev_out <= 1'b1;
      BUS.spk_dev_oe  <= 1'b0;
    end else if (CE_I) begin
      if (reg_hit && !io_read_strobe_n_s) begin
        BUS.dd_out <= {8'hFF, REG_RDATA_I};
        BUS.dd_oe  <= 2'h1;
      end else if (card_hit && !(io_read_strobe_n_s && memr_n_s)) begin
        BUS.dd_out <= word ? CARD_RDATA_I : {CARD_RDATA_I[15:8], eff[0] ? CARD_RDATA_I[15:8] : CARD_RDATA_I[7:0]};
        BUS.dd_oe  <= {word | (eff[0] & ~sbhe_n_s), 1'b1};
      end else begin
        BUS.dd_oe  <= 2'h0;
      end
      BUS.rdy_oe      <= act & (wait_d != '0);
      BUS.io16_oe     <= io_sel & IO16_MODE_I;
      BUS.mem16_oe    <= mem_sel & MEM16_MODE_I;
      BUS.nws_oe      <= card_hit & ZERO_WAIT_EN_I & ~WAIT_EN_I & ~(io_hit & IO16_MODE_I);
      BUS.chk_n       <= (chk_d == '0);
      BUS.irq         <= irq_d;
      BUS.spk_dev_out <= SPKR_AUDIO_I;
      BUS.spk_dev_oe  <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // user side: register writes land at the end of the strobe, when data is stable
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (rst) begin
      reg_wr_q     <= 1'b0;
      REG_WR_O     <= 1'b0;
      REG_ADDR_O   <= 1'b0;
      REG_WDATA_O  <= 8'h00;
      CARD_STB_O   <= 1'b0;
      CARD_IO_O    <= 1'b0;
      CARD_WR_O    <= 1'b0;
      CARD_WORD_O  <= 1'b0;
      CARD_ADDR_O  <= 24'h000000;
      CARD_WDATA_O <= 16'h0000;
      BASE_SEL_O   <= isah_pkg::SEL_RST;
    end else if (CE_I) begin
      reg_wr_q   <= reg_hit & ~io_write_strobe_n_s;
      REG_WR_O   <= reg_wr_q & ~reg_hit;
      BASE_SEL_O <= sel_q;
      if (reg_hit && !io_write_strobe_n_s) begin
        REG_ADDR_O  <= sa_s[0];
        REG_WDATA_O <= d_s[7:0];
      end
      CARD_STB_O <= card_hit & (dly_d == '0);
      if (card_hit) begin
        CARD_IO_O    <= io_hit;
        CARD_WR_O    <= wr;
        CARD_WORD_O  <= word;
        CARD_ADDR_O  <= eff;
        CARD_WDATA_O <= d_s;
      end
    end
  end
endmodule

// ### verilog/isah_host.sv
// host end: makes the bus clock and runs single io and memory cycles on command
`timescale 1ns/1ps
module isah_host #(
  parameter int SCLK_HALF = isah_pkg::SCLK_HALF
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  isah_if.host             BUS,
  input  wire logic        SYS_RESET_I,
  input  wire logic        STRAP_SEL_I,
  input  wire logic        CMD_VALID_I,
  input  wire logic        CMD_IO_I,
  input  wire logic        CMD_WR_I,
  input  wire logic        CMD_WORD_I,
  input  wire logic [23:0] CMD_ADDR_I,
  input  wire logic [15:0] CMD_WDATA_I,
  output logic             CMD_READY_O,
  output logic             RSP_VALID_O,
  output logic [15:0]      RSP_RDATA_O,
  output logic             RSP_ZWS_O,
  output logic [9:0]       IRQ_O,
  output logic             NMI_N_O,
  output logic             SPKR_O
);
  localparam int SW = 32;

  logic [SW-1:0]          raw;
  logic [SW-1:0]          syn;
  logic [15:0]            d_s;
  logic                   rdy_s;
  logic                   nws_n_s;
  logic [$clog2(SCLK_HALF+1)-1:0] div_q;
  logic                   rise;
  logic [isah_pkg::CNT_W-1:0] cnt_q;
  logic                   io_q;
  logic                   wr_q;
  logic                   zws_q;
  isah_pkg::isah_hstate_t st_q;

  assign raw = {BUS.d_lvl, BUS.rdy_lvl, BUS.io16_n_lvl, BUS.mem16_lvl, BUS.nws_n_lvl, BUS.chk_n, BUS.irq,
                BUS.spk_lvl};

  isah_sync #(.W(SW)) u_sync (
    .CLK_I (CLK_I),
    .RST_I (RST_I),
    .CE_I  (CE_I),
    .D_I   (raw),
    .Q_O   (syn)
  );

  assign d_s     = syn[31:16];
  assign rdy_s   = syn[15];
  assign nws_n_s = syn[12];
  assign rise    = (div_q == ($bits(div_q))'(SCLK_HALF - 1)) & ~BUS.sclk;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      div_q    <= '0;
      BUS.sclk <= 1'b0;
    end else if (CE_I) begin
      if (div_q == ($bits(div_q))'(SCLK_HALF - 1)) begin
        div_q    <= '0;
        BUS.sclk <= ~BUS.sclk;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BUS.system_reset_in         <= 1'b1;
      BUS.spk_host_out <= 1'b1;
      BUS.spk_host_oe  <= 1'b0;
      IRQ_O            <= '0;
      NMI_N_O          <= 1'b1;
      SPKR_O           <= 1'b1;
    end else if (CE_I) begin
      BUS.system_reset_in         <= SYS_RESET_I;
      BUS.spk_host_out <= STRAP_SEL_I;
      BUS.spk_host_oe  <= SYS_RESET_I;
      IRQ_O            <= syn[10:1];
      NMI_N_O          <= syn[11];
      SPKR_O           <= syn[0];
    end
  end

  //----------------------------------------------------------------------------
  // cycle sequencer: address phase, strobe, then wait for ready
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_q        <= isah_pkg::ISAH_IDLE;
      cnt_q       <= '0;
      io_q        <= 1'b0;
      wr_q        <= 1'b0;
      zws_q       <= 1'b0;
      BUS.la      <= 7'h00;
      BUS.sa      <= 17'h00000;
      BUS.bale    <= 1'b0;
      BUS.aen     <= 1'b0;
      BUS.sbhe_n  <= 1'b1;
      BUS.io_write_strobe_n  <= 1'b1;
      BUS.io_read_strobe_n  <= 1'b1;
      BUS.memw_n  <= 1'b1;
      BUS.memr_n  <= 1'b1;
      BUS.hd_out  <= 16'hFFFF;
      BUS.hd_oe   <= 1'b0;
      CMD_READY_O <= 1'b0;
      RSP_VALID_O <= 1'b0;
      RSP_RDATA_O <= 16'h0000;
      RSP_ZWS_O   <= 1'b0;
    end else if (CE_I) begin
      RSP_VALID_O <= 1'b0;
      case (st_q)
        isah_pkg::ISAH_IDLE: begin
          CMD_READY_O <= ~SYS_RESET_I;
          if (CMD_VALID_I && CMD_READY_O) begin
            CMD_READY_O <= 1'b0;
            io_q        <= CMD_IO_I;
            wr_q        <= CMD_WR_I;
            zws_q       <= 1'b0;
            BUS.la      <= CMD_ADDR_I[23:17];
            BUS.sa      <= CMD_ADDR_I[16:0];
            BUS.sbhe_n  <= ~(CMD_WORD_I | CMD_ADDR_I[0]);
            BUS.hd_out  <= CMD_WDATA_I;
            st_q        <= isah_pkg::ISAH_SETUP;
          end
        end
        isah_pkg::ISAH_SETUP: begin
          if (rise) begin
            BUS.bale <= 1'b1;
            st_q     <= isah_pkg::ISAH_ALE;
          end
        end
        isah_pkg::ISAH_ALE: begin
          if (rise) begin
            BUS.bale   <= 1'b0;
            BUS.io_write_strobe_n <= ~(io_q & wr_q);
            BUS.io_read_strobe_n <= ~(io_q & ~wr_q);
            BUS.memw_n <= ~(~io_q & wr_q);
            BUS.memr_n <= ~(~io_q & ~wr_q);
            BUS.hd_oe  <= wr_q;
            cnt_q      <= isah_pkg::STROBE_SCLKS;
            st_q       <= isah_pkg::ISAH_STB;
          end
        end
        isah_pkg::ISAH_STB: begin
          if (!nws_n_s) begin
            zws_q <= 1'b1;
          end
          if (rise) begin
            if (cnt_q != '0) begin
              cnt_q <= cnt_q - 1'b1;
            end
            // ready low stretches the strobe; zero-wait cuts it short
            if (rdy_s && (cnt_q <= 3'h1 || !nws_n_s)) begin
              BUS.io_write_strobe_n  <= 1'b1;
              BUS.io_read_strobe_n  <= 1'b1;
              BUS.memw_n  <= 1'b1;
              BUS.memr_n  <= 1'b1;
              BUS.hd_oe   <= 1'b0;
              BUS.sbhe_n  <= 1'b1;
              RSP_VALID_O <= 1'b1;
              RSP_RDATA_O <= d_s;
              RSP_ZWS_O   <= zws_q | ~nws_n_s;
              st_q        <= isah_pkg::ISAH_IDLE;
            end
          end
        end
        default: begin
          st_q <= isah_pkg::ISAH_IDLE;
        end
      endcase
    end
  end
endmodule

// ### verilog/isah_if.sv
// pin-level carrier joining the host end and the device end
`timescale 1ns/1ps
interface isah_if;
  logic [23:17] la;
  logic [16:0]  sa;
  logic         bale;
  logic         sclk;
  logic         io_write_strobe_n;
  logic         io_read_strobe_n;
  logic         memw_n;
  logic         memr_n;
  logic         sbhe_n;
  logic         aen;
  logic         system_reset_in;
  logic [15:0]  hd_out;
  logic         hd_oe;
  logic [15:0]  dd_out;
  logic [1:0]   dd_oe;
  logic         rdy_out;
  logic         rdy_oe;
  logic         io16_oe;
  logic         mem16_out;
  logic         mem16_oe;
  logic         nws_oe;
  logic         chk_n;
  logic [9:0]   irq;
  logic         spk_dev_out;
  logic         spk_dev_oe;
  logic         spk_host_out;
  logic         spk_host_oe;
  logic [15:0]  d_lvl;
  logic         rdy_lvl;
  logic         io16_n_lvl;
  logic         mem16_lvl;
  logic         nws_n_lvl;
  logic         spk_lvl;

  // pulled-up lines rest high; the memory width line rests low
  assign d_lvl[7:0]  = dd_oe[0] ? dd_out[7:0] : (hd_oe ? hd_out[7:0] : 8'hFF);
  assign d_lvl[15:8] = dd_oe[1] ? dd_out[15:8] : (hd_oe ? hd_out[15:8] : 8'hFF);
  assign rdy_lvl     = rdy_oe ? rdy_out : 1'b1;
  assign io16_n_lvl  = io16_oe ? 1'b0 : 1'b1;
  assign mem16_lvl   = mem16_oe ? mem16_out : 1'b0;
  assign nws_n_lvl   = nws_oe ? 1'b0 : 1'b1;
  assign spk_lvl     = spk_dev_oe ? spk_dev_out : (spk_host_oe ? spk_host_out : 1'b1);

  modport dev (
    input  la, sa, bale, sclk, io_write_strobe_n, io_read_strobe_n, memw_n, memr_n, sbhe_n, aen, system_reset_in, d_lvl, spk_lvl,
    output dd_out, dd_oe, rdy_out, rdy_oe, io16_oe, mem16_out, mem16_oe, nws_oe, chk_n, irq,
    output spk_dev_out, spk_dev_oe
  );
  modport host (
    output la, sa, bale, sclk, io_write_strobe_n, io_read_strobe_n, memw_n, memr_n, sbhe_n, aen, system_reset_in, hd_out, hd_oe,
    output spk_host_out, spk_host_oe,
    input  d_lvl, rdy_lvl, io16_n_lvl, mem16_lvl, nws_n_lvl, chk_n, irq, spk_lvl
  );
endinterface

// ### verilog/isah_pkg.sv
// shared constants and types of the host-side expansion bus interface
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package isah_pkg;
  localparam int          IRQ_LINES      = 10;
  localparam int          SOCKETS        = 2;
  localparam int          CNT_W          = 3;
  localparam logic [3:0]  IRQ_CODE_CHK   = 4'hA;
  localparam logic [15:0] REG_BASE0      = 16'h03E0;
  localparam logic [15:0] REG_BASE1      = 16'h03E2;
  localparam logic [2:0]  WAIT_SCLKS     = 3'h1;
  localparam logic [2:0]  CHK_SCLKS      = 3'h3;
  localparam logic [2:0]  MEM16_DLY_SCLKS = 3'h1;
  localparam logic [2:0]  STROBE_SCLKS   = 3'h3;
  localparam int          SCLK_HALF      = 4;
  localparam logic        SEL_RST        = 1'b0;

  typedef enum logic [1:0] {
    ISAH_IDLE  = 2'b00,
    ISAH_SETUP = 2'b01,
    ISAH_ALE   = 2'b10,
    ISAH_STB   = 2'b11
  } isah_hstate_t;
endpackage

// ### verilog/isah_sync.sv
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module isah_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK_I,
  input  wire logic         RST_I,
  input  wire logic         CE_I,
  input  wire logic [W-1:0] D_I,
  output logic      [W-1:0] Q_O
);
  logic [W-1:0] meta_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      meta_q <= '1;
      Q_O    <= '1;
    end else if (CE_I) begin
      meta_q <= D_I;
      Q_O    <= meta_q;
    end
  end
endmodule
